/* src/hbp_pkg.sv */
// constants, field layout and configuration carrier of the blanking pattern generator
// Operation
// - area odd-clock counts: A[3:0], B[7:4], C[11:8]
// - area even-clock counts use same A/B/C layout
// - each count gives zero to fifteen pulses
// - six 12-bit odd-clock repeat-area count registers
// - six separate 12-bit even-clock count registers
// - area counts define even lines in advanced mode
// - three shared 13-bit start positions, advanced mode
// - first odd selector picks even area for area 0
// - selectors two to six map odd areas 1-5
// - mode value 1 enables repeated blanking
// - multi-repeat uses start, end, length, count, toggles
// - even and odd toggle sets follow line parity
// - alternation works in normal and multi-repeat modes
// - line alternation independent of vertical alternation
// - mode field: normal, multi, advanced, test
// - start, end, length, repeat count are 13-bit
// - separate mask polarities for odd, even, last clocks
package hbp_pkg;

  // ****************************************************************
  // field layout and sizes
  // ****************************************************************
  localparam int POS_W     = 13;
  localparam int CNT_W     = 4;
  localparam int AREA_W    = 12;
  localparam int SEL_W     = 3;
  localparam int NUM_AREAS = 6;
  localparam int NUM_TOGS  = 6;
  localparam int CNT_A_LSB = 0;
  localparam int CNT_B_LSB = 4;
  localparam int CNT_C_LSB = 8;

  // ****************************************************************
  // mode codes and reset values
  // ****************************************************************
  localparam logic [1:0]       MODE_NORMAL   = 2'h0;
  localparam logic [1:0]       MODE_MULTI    = 2'h1;
  localparam logic [1:0]       MODE_ADVANCED = 2'h2;
  localparam logic [1:0]       MODE_TEST     = 2'h3;
  localparam logic [POS_W-1:0] POS_UNUSED    = 13'h1FFF;
  localparam logic [POS_W-1:0] POS_ZERO      = 13'h0000;
  localparam logic [POS_W-1:0] POS_ONE       = 13'h0001;
  localparam logic [2:0]       AREA_LAST     = 3'h5;
  localparam logic             RST_LEVEL     = 1'b0;

  // register image delivered by the serial register file
  typedef struct packed {
    logic [1:0]                          blanking_mode_select;
    logic                                odd_clock_mask_polarity;
    logic                                even_clock_mask_polarity;
    logic                                last_stage_mask_polarity;
    logic [POS_W-1:0]                    blanking_start;
    logic [POS_W-1:0]                    blanking_end;
    logic [POS_W-1:0]                    blanking_length;
    logic [POS_W-1:0]                    blanking_repeat_count;
    logic [NUM_TOGS-1:0][POS_W-1:0]      even_line_toggles;
    logic [NUM_TOGS-1:0][POS_W-1:0]      odd_line_toggles;
    logic [POS_W-1:0]                    shared_start_pos_a;
    logic [POS_W-1:0]                    shared_start_pos_b;
    logic [POS_W-1:0]                    shared_start_pos_c;
    logic [NUM_AREAS-1:0][AREA_W-1:0]    area_h1_pulse_counts;
    logic [NUM_AREAS-1:0][AREA_W-1:0]    area_h2_pulse_counts;
    logic [NUM_AREAS-1:0][SEL_W-1:0]     odd_area_select;
  } hbp_cfg_t;

  // horizontal clock pins toward the sensor
  typedef struct packed {
    logic horizontal_blanking;
    logic odd_horizontal_clock;
    logic even_horizontal_clock;
    logic last_stage_clock;
  } hbp_hclk_t;

endpackage

/* src/hbp_pattern_gen.sv */
// horizontal blanking pattern generator driving the sensor horizontal clocks
`timescale 1ns/1ps
module hbp_pattern_gen (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset,
  input  wire hbp_pkg::hbp_cfg_t           i_cfg,
  input  wire logic [hbp_pkg::POS_W-1:0]   i_pixel_count,
  input  wire logic                        i_line_odd,
  output logic                             o_horizontal_blanking,
  output logic                             o_odd_horizontal_clock,
  output logic                             o_even_horizontal_clock,
  output logic                             o_last_stage_clock
);
  import hbp_pkg::*;

  // ****************************************************************
  // usage notes
  // ****************************************************************
  // every pin is one flop behind the
  // pixel count it belongs to.
  //
  // the line timer may feed the pixel
  // count straight from its counter.
  //
  // the register image is read live;
  // rewrite it only outside blanking,
  // a change mid-window bends a segment.
  //
  // counters restart only when the
  // pixel count equals the window start.
  //
  // a timer that skips that value
  // leaves the counters free running.
  //
  // a length of zero never wraps, so
  // the window is one repetition.
  //
  // the repetition index saturates,
  // so it never wraps to area zero.
  //
  // each pulse is two pixels wide:
  // odd clock high then low, even
  // clock low then high.
  //
  // a count of fifteen fills thirty
  // pixels after its start.
  //
  // overlapping groups: group A wins,
  // then B, then C; nothing flags it.
  //
  // test mode runs the normal toggles,
  // so the pins stay defined.
  //
  // outside blanking all clocks follow
  // one phase flop running from reset.

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // pick one 4-bit pulse count out of an area register
  function automatic logic [CNT_W-1:0] count_field(input logic [AREA_W-1:0] area, input logic [1:0] which);
    logic [CNT_W-1:0] f;
    case (which)
      2'h0:    f = area[CNT_A_LSB +: CNT_W];
      2'h1:    f = area[CNT_B_LSB +: CNT_W];
      2'h2:    f = area[CNT_C_LSB +: CNT_W];
      default: f = 4'h0;
    endcase
    return f;
  endfunction

  // level after six toggles starting low: parity of toggles passed
  function automatic logic toggle_level(input logic [POS_W-1:0] pos,
                                        input logic [NUM_TOGS-1:0][POS_W-1:0] togs);
    logic lvl;
    lvl = 1'b0;
    for (int k = 0; k < NUM_TOGS; k++) begin
      if (pos >= togs[k]) begin
        lvl = ~lvl;
      end
    end
    return lvl;
  endfunction

  // {active, level}: cnt pulses of two pixels each, high half first
  function automatic logic [1:0] pulse_hit(input logic [POS_W-1:0] off,
                                           input logic [POS_W-1:0] start,
                                           input logic [CNT_W-1:0] cnt);
    logic [POS_W-1:0] d;
    logic             act;
    d   = POS_W'(off - start);
    act = (off >= start) && (d < {8'h00, cnt, 1'b0});
    return {act, ~d[0]};
  endfunction

  // ****************************************************************
  // state registers
  // ****************************************************************
  logic [POS_W-1:0] off_reg;
  logic [POS_W-1:0] idx_reg;
  logic             hclk_phase_reg;
  logic             blank_reg;
  logic             h1_pulse_reg;
  logic             h2_pulse_reg;
  logic             odd_clk_reg;
  logic             even_clk_reg;
  logic             last_clk_reg;

  // ****************************************************************
  // segment tracking for multi-repeat and advanced modes
  // ****************************************************************
  wire logic [1:0]       mode      = i_cfg.blanking_mode_select;
  wire logic             at_start  = (i_pixel_count == i_cfg.blanking_start);
  wire logic [POS_W-1:0] len_last  = POS_W'(i_cfg.blanking_length - POS_ONE);
  // zero length never matches, so one segment spans the whole window
  wire logic             seg_wrap  = (i_cfg.blanking_length != POS_ZERO) && (off_reg == len_last);
  wire logic [POS_W-1:0] off_inc   = POS_W'(off_reg + POS_ONE);
  wire logic [POS_W-1:0] idx_inc   = (idx_reg == POS_UNUSED) ? idx_reg : POS_W'(idx_reg + POS_ONE);
  wire logic [POS_W-1:0] cur_off   = (at_start || seg_wrap) ? POS_ZERO : off_inc;
  wire logic [POS_W-1:0] cur_idx   = at_start ? POS_ZERO : (seg_wrap ? idx_inc : idx_reg);
  wire logic             in_window = (i_pixel_count >= i_cfg.blanking_start) &&
                                     (i_pixel_count < i_cfg.blanking_end);

  // ****************************************************************
  // mode 0 and mode 1: toggle sets chosen by line parity
  // ****************************************************************
  wire logic [NUM_TOGS-1:0][POS_W-1:0] cur_togs =
    i_line_odd ? i_cfg.odd_line_toggles : i_cfg.even_line_toggles;
  wire logic normal_blank = toggle_level(i_pixel_count, cur_togs);
  // toggles are relative to each repetition inside the window
  wire logic multi_blank  = in_window && (cur_idx < i_cfg.blanking_repeat_count) &&
                            toggle_level(cur_off, cur_togs);

  // ****************************************************************
  // mode 2: repeat areas in order, odd lines reordered
  // ****************************************************************
  wire logic       area_run  = in_window && (cur_idx <= {10'h000, AREA_LAST});
  wire logic [2:0] even_area = cur_idx[2:0];
  wire logic [2:0] odd_area  = i_cfg.odd_area_select[even_area];
  wire logic [2:0] area      = i_line_odd ? odd_area : even_area;
  // selector values six and seven name no area and leave it empty
  wire logic       area_ok   = area <= AREA_LAST;
  wire logic [AREA_W-1:0] h1_area = area_ok ? i_cfg.area_h1_pulse_counts[area] : 12'h000;
  wire logic [AREA_W-1:0] h2_area = area_ok ? i_cfg.area_h2_pulse_counts[area] : 12'h000;
  wire logic [POS_W-1:0]  pos_a   = i_cfg.shared_start_pos_a;
  wire logic [POS_W-1:0]  pos_b   = i_cfg.shared_start_pos_b;
  wire logic [POS_W-1:0]  pos_c   = i_cfg.shared_start_pos_c;

  // a start parked at 8191 is never reached inside a segment
  wire logic [1:0] h1_a = pulse_hit(cur_off, pos_a, count_field(h1_area, 2'h0));
  wire logic [1:0] h1_b = pulse_hit(cur_off, pos_b, count_field(h1_area, 2'h1));
  wire logic [1:0] h1_c = pulse_hit(cur_off, pos_c, count_field(h1_area, 2'h2));
  wire logic [1:0] h2_a = pulse_hit(cur_off, pos_a, count_field(h2_area, 2'h0));
  wire logic [1:0] h2_b = pulse_hit(cur_off, pos_b, count_field(h2_area, 2'h1));
  wire logic [1:0] h2_c = pulse_hit(cur_off, pos_c, count_field(h2_area, 2'h2));

  // first matching start wins when groups overlap
  wire logic h1_act = area_run && (h1_a[1] || h1_b[1] || h1_c[1]);
  wire logic h1_lvl = h1_a[1] ? h1_a[0] : (h1_b[1] ? h1_b[0] : h1_c[0]);
  wire logic h2_act = area_run && (h2_a[1] || h2_b[1] || h2_c[1]);
  wire logic h2_lvl = h2_a[1] ? h2_a[0] : (h2_b[1] ? h2_b[0] : h2_c[0]);

  // ****************************************************************
  // mode decode and clock shaping
  // ****************************************************************
  // test code is treated as normal so the pins never float in an odd state
  wire logic blank_next = (mode == MODE_MULTI)    ? multi_blank :
                          (mode == MODE_ADVANCED) ? area_run    : normal_blank;
  wire logic h1_pulse_next = (mode == MODE_ADVANCED) && h1_act;
  wire logic h2_pulse_next = (mode == MODE_ADVANCED) && h2_act;
  wire logic phase_next    = ~hclk_phase_reg;

  // masked clocks sit at their own polarity during blanking
  wire logic odd_next  = blank_next ? (h1_pulse_next ? h1_lvl : i_cfg.odd_clock_mask_polarity)
                                    : phase_next;
  wire logic even_next = blank_next ? (h2_pulse_next ? ~h2_lvl : i_cfg.even_clock_mask_polarity)
                                    : ~phase_next;
  wire logic last_next = blank_next ? i_cfg.last_stage_mask_polarity : phase_next;

  // segment counters
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      off_reg <= POS_ZERO;
      idx_reg <= POS_ZERO;
    end else begin
      off_reg <= cur_off;
      idx_reg <= cur_idx;
    end
  end

  // pixel-rate phase and internal pulse flags
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      hclk_phase_reg <= RST_LEVEL;
      h1_pulse_reg   <= RST_LEVEL;
      h2_pulse_reg   <= RST_LEVEL;
    end else begin
      hclk_phase_reg <= phase_next;
      h1_pulse_reg   <= h1_pulse_next;
      h2_pulse_reg   <= h2_pulse_next;
    end
  end

  // registered pins, one cycle after the pixel count they belong to
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      blank_reg    <= RST_LEVEL;
      odd_clk_reg  <= RST_LEVEL;
      even_clk_reg <= RST_LEVEL;
      last_clk_reg <= RST_LEVEL;
    end else begin
      blank_reg    <= blank_next;
      odd_clk_reg  <= odd_next;
      even_clk_reg <= even_next;
      last_clk_reg <= last_next;
    end
  end

  assign o_horizontal_blanking   = blank_reg;
  assign o_odd_horizontal_clock  = odd_clk_reg;
  assign o_even_horizontal_clock = even_clk_reg;
  assign o_last_stage_clock      = last_clk_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  wire logic cur_h1_zero = (h1_area == 12'h000);
  wire logic unused_e    = (i_cfg.even_line_toggles[2] == POS_UNUSED) && (i_cfg.even_line_toggles[3] == POS_UNUSED) &&
                           (i_cfg.even_line_toggles[4] == POS_UNUSED) && (i_cfg.even_line_toggles[5] == POS_UNUSED);
  wire logic unused_o    = (i_cfg.odd_line_toggles[2] == POS_UNUSED) && (i_cfg.odd_line_toggles[3] == POS_UNUSED) &&
                           (i_cfg.odd_line_toggles[4] == POS_UNUSED) && (i_cfg.odd_line_toggles[5] == POS_UNUSED);

  last_mask_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_horizontal_blanking |-> o_last_stage_clock == i_cfg.last_stage_mask_polarity)
    else $error("last stage clock not at mask polarity in blanking");

  odd_mask_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_horizontal_blanking && !h1_pulse_reg) |-> o_odd_horizontal_clock == i_cfg.odd_clock_mask_polarity)
    else $error("odd clock not at mask polarity in blanking");

  even_mask_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_horizontal_blanking && !h2_pulse_reg) |-> o_even_horizontal_clock == i_cfg.even_clock_mask_polarity)
    else $error("even clock not at mask polarity in blanking");

  zero_reps_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_MULTI && i_cfg.blanking_repeat_count == POS_ZERO) |=> !o_horizontal_blanking)
    else $error("blanking with zero repetitions");

  before_window_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    ((mode == MODE_MULTI || mode == MODE_ADVANCED) && i_pixel_count < i_cfg.blanking_start)
      |=> !o_horizontal_blanking)
    else $error("blanking before window start");

  even_toggle_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_NORMAL && !i_line_odd && unused_e && i_pixel_count >= i_cfg.even_line_toggles[0] &&
     i_pixel_count < i_cfg.even_line_toggles[1] && i_pixel_count < POS_UNUSED) |=> o_horizontal_blanking)
    else $error("even line toggles not applied");

  odd_toggle_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_NORMAL && i_line_odd && unused_o && i_pixel_count >= i_cfg.odd_line_toggles[0] &&
     i_pixel_count < i_cfg.odd_line_toggles[1] && i_pixel_count < POS_UNUSED) |=> o_horizontal_blanking)
    else $error("odd line toggles not applied");

  zero_count_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_ADVANCED && area_run && cur_h1_zero)
      |=> (o_horizontal_blanking && o_odd_horizontal_clock == i_cfg.odd_clock_mask_polarity))
    else $error("pulse in area with zero count");

  free_run_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!o_horizontal_blanking && !$past(o_horizontal_blanking) && !$past(i_reset))
      |-> (o_odd_horizontal_clock != $past(o_odd_horizontal_clock) &&
           o_even_horizontal_clock == !o_odd_horizontal_clock))
    else $error("horizontal clocks not running outside blanking");

  // ****************************************************************
  // segment and area checks
  // ****************************************************************
  // a stuck counter would shift
  // every later repetition.

  // counters restart at window start
  restart_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    at_start |=> (off_reg == POS_ZERO && idx_reg == POS_ZERO))
    else $error("segment counters not restarted");

  // offset wraps at the segment end
  wrap_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!at_start && seg_wrap) |=> off_reg == POS_ZERO)
    else $error("segment offset not wrapped");

  // nothing after the window end
  multi_end_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_MULTI && i_pixel_count >= i_cfg.blanking_end) |=> !o_horizontal_blanking)
    else $error("blanking after window end");

  // six areas keep blanking up
  adv_run_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_ADVANCED && in_window && cur_idx <= {10'h000, AREA_LAST})
      |=> o_horizontal_blanking)
    else $error("repeat area not blanked");

  // no seventh area
  adv_stop_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_ADVANCED && cur_idx > {10'h000, AREA_LAST}) |=> !o_horizontal_blanking)
    else $error("blanking past last repeat area");

  // first odd pulse half is high
  h1_first_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (h1_pulse_next && h1_a[1] && cur_off == pos_a) |=> o_odd_horizontal_clock)
    else $error("odd clock pulse not high at start");

  // first even pulse half is low
  h2_first_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (h2_pulse_next && h2_a[1] && cur_off == pos_a) |=> !o_even_horizontal_clock)
    else $error("even clock pulse not low at start");

  // selector six or seven: empty area
  empty_area_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (mode == MODE_ADVANCED && area_run && !area_ok)
      |=> (o_odd_horizontal_clock == i_cfg.odd_clock_mask_polarity &&
           o_even_horizontal_clock == i_cfg.even_clock_mask_polarity))
    else $error("pulses in empty odd area");

  // pins low right after reset
  reset_out_a: assert property (@(posedge i_core_clk)
    $past(i_reset) |-> (!o_horizontal_blanking && !o_odd_horizontal_clock &&
                        !o_even_horizontal_clock && !o_last_stage_clock))
    else $error("pins not low after reset");

endmodule

/* testbench/hbp_sensor_model.sv */
// sensor-side model watching the horizontal clock pins
`timescale 1ns/1ps
module hbp_sensor_model (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire hbp_pkg::hbp_hclk_t i_hclk,
  output logic [15:0]            o_rises,
  output logic [15:0]            o_faults
);
  import hbp_pkg::*;

  logic prev_odd_reg;
  logic prev_blank_reg;

  // ****************************************************************
  // charge transfer tally and free-run phase watch
  // ****************************************************************
  // only rises inside blanking move charge; outside it the clock must alternate every pixel
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rises        <= 16'h0000;
      o_faults       <= 16'h0000;
      prev_blank_reg <= 1'b1;  // skips the first phase compare after reset
      prev_odd_reg   <= 1'b0;
    end else begin
      if (i_hclk.horizontal_blanking && prev_blank_reg && i_hclk.odd_horizontal_clock && !prev_odd_reg)
        o_rises <= o_rises + 16'h0001;
      if (!i_hclk.horizontal_blanking && !prev_blank_reg && (i_hclk.odd_horizontal_clock == prev_odd_reg))
        o_faults <= o_faults + 16'h0001;
      prev_blank_reg <= i_hclk.horizontal_blanking;
      prev_odd_reg   <= i_hclk.odd_horizontal_clock;
    end
  end
endmodule

/* testbench/hbp_pattern_gen_tb.sv */
// self-checking bench for the horizontal blanking pattern generator
`timescale 1ns/1ps
module hbp_pattern_gen_tb;
  import hbp_pkg::*;

  logic               i_core_clk   = 1'b0;
  logic               i_reset      = 1'b1;
  hbp_cfg_t           cfg          = '0;
  logic [POS_W-1:0]   pix          = '0;
  logic               line_odd     = 1'b0;
  logic               blank, hodd, heven, hlast;
  hbp_hclk_t          hclk;
  logic [15:0]        m_rise, m_fault;
  int                 n_mismatch   = 0;
  int                 total_checks = 0;
  int                 tot          = 0;
  int                 rise[6], fall[6];
  int                 h1a[6]       = '{1, 15, 0, 3, 7, 2};
  int                 h1b[6]       = '{2, 0, 1, 0, 0, 3};
  int                 h2a[6]       = '{4, 0, 2, 9, 1, 6};
  logic [2:0]         sel[6]       = '{3'h6, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  always #5 i_core_clk = ~i_core_clk;
  assign hclk = {blank, hodd, heven, hlast};

  hbp_pattern_gen dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_cfg(cfg), .i_pixel_count(pix),
    .i_line_odd(line_odd), .o_horizontal_blanking(blank), .o_odd_horizontal_clock(hodd),
    .o_even_horizontal_clock(heven), .o_last_stage_clock(hlast));
  hbp_sensor_model sensor (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_hclk(hclk), .o_rises(m_rise),
    .o_faults(m_fault));

  // ****************************************************************
  // compares, expectations and line driver
  // ****************************************************************
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp[15:0]) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask

  // toggles flip from low; multi mode counts them per repetition offset
  function automatic logic exp_blank(input int q);
    int   off;
    int   n;
    logic par;
    par = 1'b0;
    off = q;
    if (cfg.blanking_mode_select == MODE_ADVANCED)
      return (q >= cfg.blanking_start) && (q < cfg.blanking_end);
    if (cfg.blanking_mode_select == MODE_MULTI) begin
      if (q < cfg.blanking_start || q >= cfg.blanking_end) return 1'b0;
      if ((q - cfg.blanking_start) / cfg.blanking_length >= cfg.blanking_repeat_count) return 1'b0;
      off = (q - cfg.blanking_start) % cfg.blanking_length;
    end
    for (n = 0; n < NUM_TOGS; n++)
      if ((line_odd ? cfg.odd_line_toggles[n] : cfg.even_line_toggles[n]) <= off) par = ~par;
    return par;
  endfunction

  task automatic set_togs(input int e1, input int e2, input int o1, input int o2);
    for (int n = 0; n < NUM_TOGS; n++) begin
      cfg.even_line_toggles[n] = POS_UNUSED;
      cfg.odd_line_toggles[n]  = POS_UNUSED;
    end
    cfg.even_line_toggles[0] = e1;
    cfg.even_line_toggles[1] = e2;
    cfg.odd_line_toggles[0]  = o1;
    cfg.odd_line_toggles[1]  = o2;
  endtask

  // outputs seen after an edge belong to the pixel driven one cycle earlier
  task automatic run_line(input int last_pix, input logic odd);
    int   q;
    int   k;
    logic pb, po, pe;
    line_odd = odd;
    pb = 1'b0;
    po = 1'b0;
    pe = 1'b0;
    for (k = 0; k < 6; k++) begin
      rise[k] = 0;
      fall[k] = 0;
    end
    for (int p = 0; p <= last_pix + 1; p++) begin
      @(posedge i_core_clk);
      #1;
      q = p - 1;
      if (q >= 0) begin
        chk_bit("blanking", exp_blank(q), blank);
        if (blank !== 1'b1) begin
          chk_bit("even clock phase", ~hodd, heven);
          chk_bit("last stage clock", hodd, hlast);
        end else if (cfg.blanking_mode_select != MODE_ADVANCED) begin
          chk_bit("odd mask", cfg.odd_clock_mask_polarity, hodd);
          chk_bit("even mask", cfg.even_clock_mask_polarity, heven);
          chk_bit("last mask", cfg.last_stage_mask_polarity, hlast);
        end else begin
          chk_bit("area last mask", cfg.last_stage_mask_polarity, hlast);
          if (pb === 1'b1) begin
            k = (q - cfg.blanking_start) / cfg.blanking_length;
            if (k < 6 && hodd === 1'b1 && po === 1'b0) rise[k]++;
            if (k < 6 && heven === 1'b0 && pe === 1'b1) fall[k]++;
          end
        end
        pb = blank;
        po = hodd;
        pe = heven;
      end
      if (p <= last_pix) pix = p[POS_W-1:0];
    end
  endtask

  // odd lines reuse even areas through the selectors; 6 and 7 leave an area empty
  task automatic chk_areas();
    int s;
    int e1;
    for (int k = 0; k < 6; k++) begin
      s  = line_odd ? int'(sel[k]) : k;
      e1 = (s < 6) ? h1a[s] + h1b[s] : 0;
      tot += e1;
      chk_cnt("odd clock pulses", e1, rise[k][15:0]);
      chk_cnt("even clock pulses", (s < 6) ? h2a[s] : 0, fall[k][15:0]);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    for (int k = 0; k < 6; k++) begin
      cfg.area_h1_pulse_counts[k] = {4'h5, h1b[k][3:0], h1a[k][3:0]};  // C parked, start C unused
      cfg.area_h2_pulse_counts[k] = {4'h5, 4'h0, h2a[k][3:0]};
      cfg.odd_area_select[k]      = sel[k];
    end
    cfg.odd_clock_mask_polarity  = 1'b1;
    cfg.last_stage_mask_polarity = 1'b1;
    set_togs(10, 20, 30, 40);
    repeat (6) @(posedge i_core_clk);
    #1;
    chk_bit("reset blanking", 1'b0, blank);
    chk_bit("reset odd clock", 1'b0, hodd);
    i_reset = 1'b0;
    run_line(60, 1'b0);
    run_line(60, 1'b1);
    cfg.blanking_mode_select = MODE_TEST;
    run_line(60, 1'b0);
    cfg.blanking_mode_select     = MODE_MULTI;
    cfg.odd_clock_mask_polarity  = 1'b0;
    cfg.even_clock_mask_polarity = 1'b1;
    cfg.last_stage_mask_polarity = 1'b0;
    cfg.blanking_start           = 13'h0032;
    cfg.blanking_end             = 13'h00C8;
    cfg.blanking_length          = 13'h001E;
    cfg.blanking_repeat_count    = 13'h0003;
    set_togs(5, 15, 5, 15);
    run_line(220, 1'b1);
    cfg.blanking_mode_select = MODE_ADVANCED;
    cfg.blanking_start       = 13'h0064;
    cfg.blanking_end         = 13'h01CC;
    cfg.blanking_length      = 13'h003C;
    cfg.shared_start_pos_a   = 13'h0002;
    cfg.shared_start_pos_b   = 13'h0028;
    cfg.shared_start_pos_c   = POS_UNUSED;
    run_line(480, 1'b0);
    chk_areas();
    run_line(480, 1'b1);
    chk_areas();
    chk_cnt("sensor transfers", tot, m_rise);
    chk_cnt("sensor phase faults", 0, m_fault);
    wrap_up();
  end
endmodule
